/* dmc_pkg.sv */
// package: constants and carrier types for the data memory address generator registers
// What this block does
// RL1 - top bit of bitrev_control enables bit reversal
// RL2 - bit reversal only on X write generator
// RL3 - one-hot modifier is half buffer length
// RL4 - software avoids indirect read after modifier write
// RL5 - reset: pages to 0001, others cleared; the x and y end registers reset to 0001 here
// RL6 - modulo start and end need programming
// RL7 - unimplemented bits read zero, ignore writes
// RL8 - modulo_control enables and pointer selectors layout
// RL9 - end address bit 0 reads one
// RL10 - read page ten bits, write page nine
package dmc_pkg;

    // --------
    // widths and field positions
    // --------
    localparam int unsigned REG_W       = 16;
    localparam int unsigned DATA_W      = 32;
    localparam int unsigned OFS_W       = 8;
    localparam int unsigned MOD_W       = 15;
    localparam int unsigned SEL_W       = 4;
    localparam int unsigned RPAGE_W     = 10;
    localparam int unsigned WPAGE_W     = 9;
    localparam int unsigned BITREV_ENABLE_BIT    = 15;
    localparam int unsigned X_MODULO_ENABLE_BIT  = 15;
    localparam int unsigned Y_MODULO_ENABLE_BIT  = 14;
    localparam int unsigned BSEL_LSB    = 8;
    localparam int unsigned YSEL_LSB    = 4;
    localparam int unsigned XSEL_LSB    = 0;

    // --------
    // register byte offsets
    // --------
    localparam logic [OFS_W-1:0] OFS_READ_PAGE  = 8'h00;
    localparam logic [OFS_W-1:0] OFS_WRITE_PAGE = 8'h04;
    localparam logic [OFS_W-1:0] OFS_MODULO_CONTROL     = 8'h08;
    localparam logic [OFS_W-1:0] OFS_X_START    = 8'h0c;
    localparam logic [OFS_W-1:0] OFS_X_END      = 8'h10;
    localparam logic [OFS_W-1:0] OFS_Y_START    = 8'h14;
    localparam logic [OFS_W-1:0] OFS_Y_END      = 8'h18;
    localparam logic [OFS_W-1:0] OFS_BITREV     = 8'h1c;
    localparam logic [OFS_W-1:0] OFS_PRIORITY   = 8'h20;
    localparam logic [OFS_W-1:0] OFS_XW_STATUS  = 8'h24;

    // --------
    // reset values and implemented-bit masks
    // --------
    localparam logic [REG_W-1:0] RST_PAGE    = 16'h0001;
    localparam logic [REG_W-1:0] RST_ZERO    = 16'h0000;
    localparam logic [REG_W-1:0] MASK_RPAGE  = 16'h03ff;
    localparam logic [REG_W-1:0] MASK_WPAGE  = 16'h01ff;
    localparam logic [REG_W-1:0] MASK_MODULO_CONTROL = 16'hcfff;
    localparam logic [REG_W-1:0] MASK_ADDR   = 16'hfffe;
    localparam logic [REG_W-1:0] MASK_FULL   = 16'hffff;
    localparam logic [REG_W-1:0] ONES_END    = 16'h0001;
    localparam logic [REG_W-1:0] WORD_BYTES  = 16'h0002;

    // --------
    // carrier types
    // --------
    typedef struct packed {
        logic [REG_W-1:0] read_page;
        logic [REG_W-1:0] write_page;
        logic [REG_W-1:0] modulo_control;
        logic [REG_W-1:0] x_modulo_start;
        logic [REG_W-1:0] x_modulo_end;
        logic [REG_W-1:0] y_modulo_start;
        logic [REG_W-1:0] y_modulo_end;
        logic [REG_W-1:0] bitrev_control;
        logic [REG_W-1:0] bus_master_priority;
    } dmc_regs_t;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [OFS_W-1:0]  paddr;
        logic [DATA_W-1:0] pwdata;
        logic [3:0]        pstrb;
    } dmc_apb_req_t;

    typedef struct packed {
        logic              pready;
        logic [DATA_W-1:0] prdata;
        logic              pslverr;
    } dmc_apb_rsp_t;

    typedef struct packed {
        logic             valid;
        logic [REG_W-1:0] addr;
        logic [REG_W-1:0] step;
    } dmc_xw_req_t;

    typedef enum logic [1:0] {
        APB_IDLE   = 2'b01,
        APB_ACCESS = 2'b10
    } dmc_apb_state_t;

endpackage : dmc_pkg

/* dmc_apb_slave.sv */
// module: apb slave front end, zero wait states, registered read data
module dmc_apb_slave
(
    // clock and reset
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_reset_n,
    // bus side
    input  wire dmc_pkg::dmc_apb_req_t i_req,
    output dmc_pkg::dmc_apb_rsp_t     o_rsp,
    // register side
    input  wire logic                 i_hit,
    input  wire logic [15:0]          i_rdata,
    output logic                      o_wr_en,
    output logic [15:0]               o_wmask
);

    // --------
    // state
    // --------
    typedef struct packed {
        dmc_pkg::dmc_apb_state_t st;
        logic [15:0]             rdata;
        logic                    err;
    } dmc_apb_s_t;

    dmc_apb_s_t s_q;
    dmc_apb_s_t s_d;
    logic       setup;
    logic       access;

    assign setup  = i_req.psel & ~i_req.penable;
    assign access = i_req.psel & i_req.penable & (s_q.st == dmc_pkg::APB_ACCESS);

    always_comb
    begin
        s_d = s_q;
        case (s_q.st)
            dmc_pkg::APB_IDLE:
            begin
                if (setup)
                begin
                    s_d.st = dmc_pkg::APB_ACCESS;
                end
            end
            dmc_pkg::APB_ACCESS:
            begin
                s_d.st = setup ? dmc_pkg::APB_ACCESS : dmc_pkg::APB_IDLE;
            end
            default:
            begin
                s_d.st = dmc_pkg::APB_IDLE;
            end
        endcase
        // read data is taken in the setup cycle so it can come from a flop
        if (setup)
        begin
            s_d.err   = ~i_hit;
            s_d.rdata = (i_hit & ~i_req.pwrite) ? i_rdata : 16'h0000;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            s_q <= '{st: dmc_pkg::APB_IDLE, rdata: 16'h0000, err: 1'b0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // --------
    // answer and write strobe
    // --------
    assign o_rsp.pready  = access;
    assign o_rsp.prdata  = {16'h0000, s_q.rdata};
    assign o_rsp.pslverr = access & s_q.err;
    assign o_wr_en       = access & i_req.pwrite & ~s_q.err;
    assign o_wmask       = {{8{i_req.pstrb[1]}}, {8{i_req.pstrb[0]}}};

endmodule : dmc_apb_slave

/* dmc_bitrev_agu.sv */
// module: x write address step, linear or reverse-carry
module dmc_bitrev_agu
(
    // clock and reset
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_reset_n,
    // configuration
    input  wire logic                 i_enable,
    input  wire logic [14:0]          i_modifier,
    // address request
    input  wire dmc_pkg::dmc_xw_req_t i_req,
    output logic [15:0]               o_addr,
    output logic                      o_valid
);

    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
    } dmc_agu_s_t;

    dmc_agu_s_t  s_q;
    dmc_agu_s_t  s_d;
    logic [15:0] mod_bytes;
    logic [15:0] rev_addr;
    logic [15:0] rev_mod;
    logic [16:0] rev_sum;
    logic [15:0] rev_next;
    logic [16:0] lin_sum;

    // modifier counts words, address counts bytes: half buffer in bytes
    assign mod_bytes = {i_modifier, 1'b0}; // RL3

    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1)
        begin : g_rev
            assign rev_addr[g] = i_req.addr[15-g];
            assign rev_mod[g]  = mod_bytes[15-g];
            assign rev_next[g] = rev_sum[15-g];
        end
    endgenerate

    // carry runs from msb to lsb; a non one-hot modifier still adds
    assign rev_sum = {1'b0, rev_addr} + {1'b0, rev_mod};
    assign lin_sum = {1'b0, i_req.addr} + {1'b0, i_req.step};

    // modifier is used live; a write just before a request is software's hazard
    always_comb
    begin
        s_d       = s_q;
        s_d.valid = i_req.valid;
        if (i_req.valid)
        begin
            s_d.addr = i_enable ? rev_next : lin_sum[15:0]; // RL1 RL2
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            s_q <= '{valid: 1'b0, addr: 16'h0000};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign o_addr  = s_q.addr;
    assign o_valid = s_q.valid;

endmodule : dmc_bitrev_agu

/* dmc_agu_regs.sv */
// module: top of the data memory address generator register bank
//
// The APB interface to the registers and the address map were chosen for this implementation.
module dmc_agu_regs
#(
    parameter int unsigned ADDR_W = 8
)
(
    // clock and reset
    input  wire logic                       i_ref_clk,
    input  wire logic                       i_reset_n,
    // apb slave
    input  wire logic                       i_psel,
    input  wire logic                       i_penable,
    input  wire logic                       i_pwrite,
    input  wire logic [ADDR_W-1:0]          i_paddr,
    input  wire logic [31:0]                i_pwdata,
    input  wire logic [3:0]                 i_pstrb,
    output logic                            o_pready,
    output logic [31:0]                     o_prdata,
    output logic                            o_pslverr,
    // x write address generator
    input  wire logic                       i_xw_req,
    input  wire logic [15:0]                i_xw_addr,
    output logic [15:0]                     o_xw_addr,
    output logic                            o_xw_valid,
    // configuration out
    output logic                            o_x_modulo_enable,
    output logic                            o_y_modulo_enable,
    output logic [3:0]                      o_bitrev_pointer_select,
    output logic [3:0]                      o_y_pointer_select,
    output logic [3:0]                      o_x_pointer_select,
    output logic [15:0]                     o_x_modulo_start,
    output logic [15:0]                     o_x_modulo_end,
    output logic [15:0]                     o_y_modulo_start,
    output logic [15:0]                     o_y_modulo_end,
    output logic [9:0]                      o_read_page,
    output logic [8:0]                      o_write_page,
    output logic [15:0]                     o_bus_master_priority,
    output logic                            o_bitrev_enable,
    output logic [14:0]                     o_bitrev_modifier
);

    // --------
    // elaboration checks
    // --------
    if (ADDR_W < dmc_pkg::OFS_W || ADDR_W > 32)
    begin : g_bad_addr_w
        $error("ADDR_W must lie between 8 and 32");
    end

    // --------
    // declarations
    // --------
    dmc_pkg::dmc_regs_t    s_q;
    dmc_pkg::dmc_regs_t    s_d;
    dmc_pkg::dmc_apb_req_t apb_req;
    dmc_pkg::dmc_apb_rsp_t apb_rsp;
    dmc_pkg::dmc_xw_req_t  xw_req;
    logic                  wr_en;
    logic [15:0]           wmask;
    logic [15:0]           wdata;
    logic                  hit;
    logic [15:0]           rdata;
    logic                  upper_zero;
    logic [7:0]            word_ofs;
    logic [15:0]           xw_addr;
    logic                  xw_valid;

    // --------
    // merge a write into a register
    // --------
    // byte lanes keep untouched bits; unimplemented bits are dropped
    // and bits that read as one are forced back in
    function automatic logic [15:0] dmc_merge
    (
        input logic [15:0] old_v,
        input logic [15:0] new_v,
        input logic [15:0] lane_m,
        input logic [15:0] impl_m,
        input logic [15:0] ones_m
    );
        logic [15:0] mixed;
        mixed = (old_v & ~lane_m) | (new_v & lane_m);
        return (mixed & impl_m) | ones_m; // RL7
    endfunction : dmc_merge

    // --------
    // apb front end
    // --------
    assign apb_req.psel    = i_psel;
    assign apb_req.penable = i_penable;
    assign apb_req.pwrite  = i_pwrite;
    assign apb_req.paddr   = i_paddr[7:0];
    assign apb_req.pwdata  = i_pwdata;
    assign apb_req.pstrb   = i_pstrb;

    dmc_apb_slave u_apb
    (
        .i_ref_clk (i_ref_clk),
        .i_reset_n (i_reset_n),
        .i_req     (apb_req),
        .o_rsp     (apb_rsp),
        .i_hit     (hit),
        .i_rdata   (rdata),
        .o_wr_en   (wr_en),
        .o_wmask   (wmask)
    );

    assign o_pready  = apb_rsp.pready;
    assign o_prdata  = apb_rsp.prdata;
    assign o_pslverr = apb_rsp.pslverr;
    assign wdata     = i_pwdata[15:0];

    // --------
    // address decode
    // --------
    // aliases above the decoded window would hide software bugs, so refuse them
    if (ADDR_W > dmc_pkg::OFS_W)
    begin : g_upper
        assign upper_zero = ~|i_paddr[ADDR_W-1:dmc_pkg::OFS_W];
    end
    else
    begin : g_no_upper
        assign upper_zero = 1'b1;
    end

    assign word_ofs = {i_paddr[7:2], 2'b00};

    always_comb
    begin
        hit   = upper_zero;
        rdata = 16'h0000;
        case (word_ofs)
            dmc_pkg::OFS_READ_PAGE:
            begin
                rdata = s_q.read_page & dmc_pkg::MASK_RPAGE; // RL10
            end
            dmc_pkg::OFS_WRITE_PAGE:
            begin
                rdata = s_q.write_page & dmc_pkg::MASK_WPAGE; // RL10
            end
            dmc_pkg::OFS_MODULO_CONTROL:
            begin
                rdata = s_q.modulo_control & dmc_pkg::MASK_MODULO_CONTROL; // RL7
            end
            dmc_pkg::OFS_X_START:
            begin
                rdata = s_q.x_modulo_start & dmc_pkg::MASK_ADDR;
            end
            dmc_pkg::OFS_X_END:
            begin
                rdata = s_q.x_modulo_end | dmc_pkg::ONES_END; // RL9
            end
            dmc_pkg::OFS_Y_START:
            begin
                rdata = s_q.y_modulo_start & dmc_pkg::MASK_ADDR;
            end
            dmc_pkg::OFS_Y_END:
            begin
                rdata = s_q.y_modulo_end | dmc_pkg::ONES_END; // RL9
            end
            dmc_pkg::OFS_BITREV:
            begin
                rdata = s_q.bitrev_control;
            end
            dmc_pkg::OFS_PRIORITY:
            begin
                rdata = s_q.bus_master_priority;
            end
            dmc_pkg::OFS_XW_STATUS:
            begin
                rdata = xw_addr;
            end
            default:
            begin
                hit = 1'b0;
            end
        endcase
    end

    // --------
    // register writes
    // --------
    // the status word is read only; a write there is dropped quietly
    always_comb
    begin
        s_d = s_q;
        if (wr_en)
        begin
            case (word_ofs)
                dmc_pkg::OFS_READ_PAGE:
                begin
                    s_d.read_page = dmc_merge(s_q.read_page, wdata, wmask,
                                              dmc_pkg::MASK_RPAGE,
                                              dmc_pkg::RST_ZERO); // RL10
                end
                dmc_pkg::OFS_WRITE_PAGE:
                begin
                    s_d.write_page = dmc_merge(s_q.write_page, wdata, wmask,
                                               dmc_pkg::MASK_WPAGE,
                                               dmc_pkg::RST_ZERO); // RL10
                end
                dmc_pkg::OFS_MODULO_CONTROL:
                begin
                    s_d.modulo_control = dmc_merge(s_q.modulo_control, wdata,
                                                   wmask, dmc_pkg::MASK_MODULO_CONTROL,
                                                   dmc_pkg::RST_ZERO); // RL8
                end
                dmc_pkg::OFS_X_START:
                begin
                    s_d.x_modulo_start = dmc_merge(s_q.x_modulo_start, wdata,
                                                   wmask, dmc_pkg::MASK_ADDR,
                                                   dmc_pkg::RST_ZERO); // RL6
                end
                dmc_pkg::OFS_X_END:
                begin
                    s_d.x_modulo_end = dmc_merge(s_q.x_modulo_end, wdata,
                                                 wmask, dmc_pkg::MASK_ADDR,
                                                 dmc_pkg::ONES_END); // RL9
                end
                dmc_pkg::OFS_Y_START:
                begin
                    s_d.y_modulo_start = dmc_merge(s_q.y_modulo_start, wdata,
                                                   wmask, dmc_pkg::MASK_ADDR,
                                                   dmc_pkg::RST_ZERO); // RL6
                end
                dmc_pkg::OFS_Y_END:
                begin
                    s_d.y_modulo_end = dmc_merge(s_q.y_modulo_end, wdata,
                                                 wmask, dmc_pkg::MASK_ADDR,
                                                 dmc_pkg::ONES_END); // RL9
                end
                dmc_pkg::OFS_BITREV:
                begin
                    s_d.bitrev_control = dmc_merge(s_q.bitrev_control, wdata,
                                                   wmask, dmc_pkg::MASK_FULL,
                                                   dmc_pkg::RST_ZERO); // RL2
                end
                dmc_pkg::OFS_PRIORITY:
                begin
                    s_d.bus_master_priority = dmc_merge(s_q.bus_master_priority,
                                                        wdata, wmask,
                                                        dmc_pkg::MASK_FULL,
                                                        dmc_pkg::RST_ZERO);
                end
                default:
                begin
                    s_d = s_q;
                end
            endcase
        end
    end

    // modulo address words have no documented reset; start words reset to zero and end words to 0001, which keeps lint and x-prop quiet
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            s_q <= '{read_page:           dmc_pkg::RST_PAGE,
                     write_page:          dmc_pkg::RST_PAGE,
                     modulo_control:      dmc_pkg::RST_ZERO,
                     x_modulo_start:      dmc_pkg::RST_ZERO,
                     x_modulo_end:        dmc_pkg::ONES_END,
                     y_modulo_start:      dmc_pkg::RST_ZERO,
                     y_modulo_end:        dmc_pkg::ONES_END,
                     bitrev_control:      dmc_pkg::RST_ZERO,
                     bus_master_priority: dmc_pkg::RST_ZERO}; // RL5 RL6
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // --------
    // x write address generator
    // --------
    assign xw_req.valid = i_xw_req;
    assign xw_req.addr  = i_xw_addr;
    assign xw_req.step  = dmc_pkg::WORD_BYTES;

    dmc_bitrev_agu u_xw_agu
    (
        .i_ref_clk  (i_ref_clk),
        .i_reset_n  (i_reset_n),
        .i_enable   (s_q.bitrev_control[dmc_pkg::BITREV_ENABLE_BIT]),
        .i_modifier (s_q.bitrev_control[dmc_pkg::MOD_W-1:0]),
        .i_req      (xw_req),
        .o_addr     (xw_addr),
        .o_valid    (xw_valid)
    );

    assign o_xw_addr  = xw_addr;
    assign o_xw_valid = xw_valid;

    // --------
    // configuration outputs
    // --------
    assign o_x_modulo_enable       = s_q.modulo_control[dmc_pkg::X_MODULO_ENABLE_BIT]; // RL8
    assign o_y_modulo_enable       = s_q.modulo_control[dmc_pkg::Y_MODULO_ENABLE_BIT]; // RL8
    assign o_bitrev_pointer_select =
        s_q.modulo_control[dmc_pkg::BSEL_LSB +: dmc_pkg::SEL_W]; // RL8
    assign o_y_pointer_select      =
        s_q.modulo_control[dmc_pkg::YSEL_LSB +: dmc_pkg::SEL_W]; // RL8
    assign o_x_pointer_select      =
        s_q.modulo_control[dmc_pkg::XSEL_LSB +: dmc_pkg::SEL_W]; // RL8
    assign o_x_modulo_start        = s_q.x_modulo_start & dmc_pkg::MASK_ADDR;
    assign o_x_modulo_end          = s_q.x_modulo_end | dmc_pkg::ONES_END; // RL9
    assign o_y_modulo_start        = s_q.y_modulo_start & dmc_pkg::MASK_ADDR;
    assign o_y_modulo_end          = s_q.y_modulo_end | dmc_pkg::ONES_END; // RL9
    assign o_read_page             = s_q.read_page[dmc_pkg::RPAGE_W-1:0];
    assign o_write_page            = s_q.write_page[dmc_pkg::WPAGE_W-1:0];
    assign o_bus_master_priority   = s_q.bus_master_priority;
    assign o_bitrev_enable         = s_q.bitrev_control[dmc_pkg::BITREV_ENABLE_BIT]; // RL1
    assign o_bitrev_modifier       = s_q.bitrev_control[dmc_pkg::MOD_W-1:0];

endmodule : dmc_agu_regs

/* dmc_agu_regs_asserts.sv */
// checker: port properties of the address generator register bank
module dmc_agu_regs_asserts
#(
    parameter int unsigned ADDR_W = 8
)
(
    input wire logic              i_ref_clk,
    input wire logic              i_reset_n,
    input wire logic              i_psel,
    input wire logic              i_penable,
    input wire logic              i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [31:0]       i_pwdata,
    input wire logic [3:0]        i_pstrb,
    input wire logic [31:0]       o_prdata,
    input wire logic              o_pslverr,
    input wire logic              i_xw_req,
    input wire logic [15:0]       i_xw_addr,
    input wire logic [15:0]       o_xw_addr,
    input wire logic              o_xw_valid,
    input wire logic              o_x_modulo_enable,
    input wire logic [3:0]        o_x_pointer_select,
    input wire logic [15:0]       o_x_modulo_end,
    input wire logic [9:0]        o_read_page,
    input wire logic [8:0]        o_write_page,
    input wire logic              o_bitrev_enable,
    input wire logic [14:0]       o_bitrev_modifier
);
    // --------
    // properties
    // --------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);
    logic [7:0] a8;
    logic       wr;
    // upper address bits are left out: the bench never drives them
    assign a8 = i_paddr[7:0];
    assign wr = i_psel && i_penable && i_pwrite && (i_pstrb[1:0] == 2'b11);

    chk_xw_valid_next: assert property (i_xw_req |=> o_xw_valid)
        else $error("x write step not answered");
    chk_xw_valid_cause: assert property (o_xw_valid |-> $past(i_xw_req))
        else $error("x write step without request");
    chk_linear_step: assert property (i_xw_req && !o_bitrev_enable |=>
        o_xw_addr == $past(i_xw_addr) + 16'h0002) else $error("linear step wrong");
    chk_bitrev_write: assert property (wr && a8 == 8'h1c |=>
        {o_bitrev_enable, o_bitrev_modifier} == $past(i_pwdata[15:0]))
        else $error("bit reversal control not loaded");
    chk_wpage_width: assert property (wr && a8 == 8'h04 |=>
        o_write_page == $past(i_pwdata[8:0])) else $error("write page not loaded");
    chk_page_reset: assert property ($rose(i_reset_n) |->
        o_read_page == 10'h001 && o_write_page == 9'h001) else $error("page reset wrong");
    chk_end_odd: assert property (o_x_modulo_end[0])
        else $error("end address bit 0 low");
    chk_high_zero: assert property (o_prdata[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    chk_modulo_control_fields: assert property (wr && a8 == 8'h08 |=>
        o_x_modulo_enable == $past(i_pwdata[15]) && o_x_pointer_select == $past(i_pwdata[3:0]))
        else $error("modulo control fields wrong");

    cover property (o_xw_valid && o_bitrev_enable);
    cover property (o_pslverr);
    cover property (wr && a8 == 8'h1c);
endmodule : dmc_agu_regs_asserts

bind dmc_agu_regs dmc_agu_regs_asserts #(.ADDR_W(ADDR_W)) u_dmc_agu_regs_asserts (.*);

/* data_memory_agu_control_regs_tb_top.sv */
// testbench: register access and x write stepping of the register bank
module data_memory_agu_control_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // --------
    // signals, tables and tasks
    // --------
    logic i_ref_clk = 1'b0, i_reset_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic i_xw_req = 1'b0, o_pready, o_pslverr, o_xw_valid, o_x_modulo_enable, o_y_modulo_enable;
    logic o_bitrev_enable;
    logic [7:0]  i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0, o_prdata;
    logic [3:0]  i_pstrb = 4'hf, o_bitrev_pointer_select, o_y_pointer_select, o_x_pointer_select;
    logic [15:0] i_xw_addr = 16'h0, o_xw_addr, o_x_modulo_start, o_x_modulo_end, o_y_modulo_start;
    logic [15:0] o_y_modulo_end, o_bus_master_priority;
    logic [9:0]  o_read_page;
    logic [8:0]  o_write_page;
    logic [14:0] o_bitrev_modifier;
    int          err_total = 0;
    int          check_count = 0;
    logic [31:0] rq[$];
    logic [31:0] xq[$];
    wire [143:0] cfg = {6'h0, o_read_page, 7'h0, o_write_page, o_x_modulo_enable,
        o_y_modulo_enable, 2'h0, o_bitrev_pointer_select, o_y_pointer_select,
        o_x_pointer_select, o_x_modulo_start, o_x_modulo_end, o_y_modulo_start,
        o_y_modulo_end, o_bitrev_enable, o_bitrev_modifier, o_bus_master_priority};
    logic [15:0] msk[9] = '{16'h03ff, 16'h01ff, 16'hcfff, 16'hfffe, 16'hfffe, 16'hfffe,
                            16'hfffe, 16'hffff, 16'hffff};

    dmc_agu_regs u_dmc_agu_regs (.*);

    initial forever #20 i_ref_clk = ~i_ref_clk;

    function automatic logic [15:0] rev(input logic [15:0] v);
        for (int k = 0; k < 16; k++) rev[k] = v[15-k];
    endfunction : rev

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e)
        begin
            err_total++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    // request stands until pready is sampled high
    task automatic apb(input logic w, logic [7:0] a, logic [31:0] d);
        @(posedge i_ref_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_ref_clk);
        i_penable <= 1'b1;
        @(posedge i_ref_clk);
        while (o_pready !== 1'b1) @(posedge i_ref_clk);
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd

    task automatic tally_and_finish;
        chk("pending notes", 32'h0, 32'(rq.size() + xq.size()));
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    always @(posedge i_ref_clk)
    begin
        if (i_psel && i_penable && !i_pwrite && o_pready === 1'b1)
            chk("read", rq.pop_front(), o_prdata | {o_pslverr, 31'h0});
        if (o_xw_valid === 1'b1)
            chk("x write address", xq.pop_front(), {16'h0, o_xw_addr});
    end

    initial
    begin
        repeat (20000) @(posedge i_ref_clk);
        err_total++;
        tally_and_finish();
    end

    // --------
    // tests
    // --------
    initial
    begin
        logic [31:0] d;
        logic [15:0] a;
        logic [15:0] m;
        logic [15:0] e;
        logic [3:0]  s;
        void'($urandom(32'h734d29cd));
        repeat (16) @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
        for (int i = 0; i < 9; i++) if (i < 3 || i > 6) rd(8'(4 * i), (i < 2) ? 32'h1 : 32'h0);
        $display("test reset values done");
        for (int i = 0; i < 9; i++)
            for (int j = 0; j < 3; j++)
            begin
                d = (j == 0) ? 32'hffffffff : (j == 1) ? 32'h0 : $urandom;
                s = (j == 2) ? 4'($urandom) : 4'hf;
                i_pstrb <= s;
                apb(1'b1, 8'(4 * i), d);
                e = (d[15:0] & {{8{s[1]}}, {8{s[0]}}} & msk[i]) | {15'h0, i == 4 || i == 6};
                rd(8'(4 * i), {16'h0, e});
                chk("config", {16'h0, e}, {16'h0, cfg[16 * (8 - i) +: 16]});
            end
        i_pstrb <= 4'hf;
        rd(8'h28, 32'h80000000);
        $display("test register masks done");
        // b = 15 steps linearly
        for (int b = 0; b < 16; b++)
        begin
            m = 16'h1 << b;
            apb(1'b1, 8'h1c, (b == 15) ? 32'h0 : {16'h0, 16'h8000 | m});
            for (int k = 0; k < 3; k++)
            begin
                a = 16'($urandom) & 16'hfffe;
                @(posedge i_ref_clk);
                i_xw_req <= 1'b1;
                i_xw_addr <= a;
                xq.push_back({16'h0, (b == 15) ? a + 16'h2 : rev(rev(a) + rev(m << 1))});
            end
            @(posedge i_ref_clk);
            i_xw_req <= 1'b0;
        end
        $display("test address stepping done");
        @(posedge i_ref_clk);
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
        rd(8'h00, 32'h1);
        rd(8'h04, 32'h1);
        rd(8'h1c, 32'h0);
        repeat (3) @(posedge i_ref_clk);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule : data_memory_agu_control_regs_tb_top
